/* hdl/cwd_pkg.sv */
// Package for the configuration word decoder: field layout, encodings, register map.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package cwd_pkg;

  // ==========================================================================
  // Word layout
  localparam int unsigned WORD_W       = 14;
  localparam int unsigned CP_HI_LSB    = 12;
  localparam int unsigned BORV_LSB     = 10;
  localparam int unsigned CP_MID_LSB   = 8;
  localparam int unsigned UNIMPL_BIT   = 7;
  localparam int unsigned BOREN_BIT    = 6;
  localparam int unsigned CP_LO_LSB    = 4;
  localparam int unsigned POWERUP_TIMER_BIT     = 3;
  localparam int unsigned WDT_BIT      = 2;
  localparam int unsigned OSC_LSB      = 0;

  // Erased word: every bit one, protection off
  localparam logic [13:0] WORD_ERASED  = 14'h3FFF;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    CWD_OSC_LP = 2'h0,
    CWD_OSC_XT = 2'h1,
    CWD_OSC_HS = 2'h2,
    CWD_OSC_RC = 2'h3
  } cwd_osc_type;

  localparam logic [1:0] CP_OFF        = 2'h3;
  localparam logic [1:0] CP_UPPER      = 2'h2;
  localparam logic [1:0] CP_UPPER3Q    = 2'h1;
  localparam logic [1:0] CP_ALL        = 2'h0;

  localparam logic [11:0] ADDR_TOP     = 12'hFFF;
  localparam logic [11:0] ADDR_0800    = 12'h800;
  localparam logic [11:0] ADDR_0400    = 12'h400;
  localparam logic [11:0] ADDR_0000    = 12'h000;

  // Trip level in tenths of a volt
  localparam logic [5:0] BOR_25        = 6'h19;
  localparam logic [5:0] BOR_27        = 6'h1B;
  localparam logic [5:0] BOR_42        = 6'h2A;
  localparam logic [5:0] BOR_45        = 6'h2D;

  typedef struct packed {
    logic        prot_on;
    logic [11:0] prot_lo;
    logic [11:0] prot_hi;
    logic [5:0]  bor_tenths;
    logic        bor_en;
    logic        powerup_timer_en;
    logic        wdt_en;
    cwd_osc_type osc_mode;
    logic        ext_clk_ok;
  } cwd_dec_type;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] OFS_WORD     = 12'h000;
  localparam logic [11:0] OFS_DECODE   = 12'h004;
  localparam logic [11:0] OFS_RANGE    = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00C;

endpackage : cwd_pkg

/* hdl/cwd_field_dec.sv */
// Pure decode of a configuration word into its settings.
// Assumes the word is stable; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module cwd_field_dec (
  input  wire logic [13:0]        word_in, // Configuration word
  output cwd_pkg::cwd_dec_type    dec_out  // Decoded settings
);

  logic [1:0] cp;
  assign cp = word_in[cwd_pkg::CP_HI_LSB +: 2];

  always_comb begin
    dec_out = '0;
    case (cp)
      cwd_pkg::CP_UPPER: begin
        dec_out.prot_on = 1'b1;
        dec_out.prot_lo = cwd_pkg::ADDR_0800;
      end
      cwd_pkg::CP_UPPER3Q: begin
        dec_out.prot_on = 1'b1;
        dec_out.prot_lo = cwd_pkg::ADDR_0400;
      end
      cwd_pkg::CP_ALL: begin
        dec_out.prot_on = 1'b1;
        dec_out.prot_lo = cwd_pkg::ADDR_0000;
      end
      default: begin
        dec_out.prot_on = 1'b0;
        dec_out.prot_lo = cwd_pkg::ADDR_0000;
      end
    endcase
    dec_out.prot_hi = dec_out.prot_on ? cwd_pkg::ADDR_TOP : cwd_pkg::ADDR_0000;
    case (word_in[cwd_pkg::BORV_LSB +: 2])
      2'h3:    dec_out.bor_tenths = cwd_pkg::BOR_25;
      2'h2:    dec_out.bor_tenths = cwd_pkg::BOR_27;
      2'h1:    dec_out.bor_tenths = cwd_pkg::BOR_42;
      default: dec_out.bor_tenths = cwd_pkg::BOR_45;
    endcase
    dec_out.bor_en     = word_in[cwd_pkg::BOREN_BIT];
    dec_out.powerup_timer_en    = ~word_in[cwd_pkg::POWERUP_TIMER_BIT];
    dec_out.wdt_en     = word_in[cwd_pkg::WDT_BIT];
    dec_out.osc_mode   = cwd_pkg::cwd_osc_type'(word_in[cwd_pkg::OSC_LSB +: 2]);
    dec_out.ext_clk_ok = (dec_out.osc_mode == cwd_pkg::CWD_OSC_HS);
  end

endmodule // cwd_field_dec
`default_nettype wire

/* hdl/cwd_top.sv */
// Configuration word decoder with an APB register view.
// Assumes cfg_word_in is static non-volatile bits, sampled after reset release.
//
// Functional notes
// - Protect field: 11 none, 10 0800-0FFF, 01 0400-0FFF, 00 all.
// - Bits 11-10 pick trip: 11 2.5V, 10 2.7V, 01 4.2V, 00 4.5V.
// - Bit 6 high enables brown-out reset, low disables it.
// - Bit 3 is active low power-up timer enable.
// - Bit 2 high runs the watchdog, low keeps it off.
// - Two select bits choose one of four oscillator modes.
// - External clock drive allowed only in high-speed mode.
`timescale 1ns/1ps
`default_nettype none
module cwd_top (
  input  wire logic        clk_sys_in,          // 250 MHz clock
  input  wire logic        rstn_in,             // Async reset, active low
  input  wire logic [13:0] cfg_word_in,         // Programmed word, static
  input  wire logic        psel_in,             // APB select
  input  wire logic        penable_in,          // APB enable
  input  wire logic        pwrite_in,           // APB write
  input  wire logic [11:0] paddr_in,            // APB byte address
  input  wire logic [31:0] pwdata_in,           // APB write data
  output logic             pready_out,          // APB ready
  output logic      [31:0] prdata_out,          // APB read data
  output logic             pslverr_out,         // APB error
  output logic             cfg_valid_out,       // Word latched; decoded outputs follow one cycle later
  output logic             code_protect_on_out, // Protection active
  output logic      [11:0] protect_lo_out,      // First protected address
  output logic      [11:0] protect_hi_out,      // Last protected address
  output logic      [5:0]  brownout_trip_voltage_out, // Trip level, tenths of a volt
  output logic             brownout_reset_en_out,     // Brown-out reset on
  output logic             powerup_timer_en_out,      // Power-up timer on
  output logic             watchdog_en_out,           // Watchdog runs
  output logic      [1:0]  osc_mode_sel_out,          // Oscillator mode
  output logic             ext_clock_allowed_out      // External clock allowed
);

  // ==========================================================================
  // Sampling: word passes two flops, then is latched once
  logic [13:0] sync1_q, sync1_d;
  logic [13:0] sync2_q, sync2_d;
  logic [13:0] word_q, word_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        valid_q, valid_d;

  always_comb begin
    sync1_d = cfg_word_in;
    sync2_d = sync1_q;
    cnt_d   = cnt_q;
    word_d  = word_q;
    valid_d = valid_q;
    if (!valid_q) begin
      // Wait until the pipe holds a post-reset sample
      if (cnt_q == 2'h2) begin
        word_d  = sync2_q;
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= cwd_pkg::WORD_ERASED;
      sync2_q <= cwd_pkg::WORD_ERASED;
      word_q  <= cwd_pkg::WORD_ERASED;
      cnt_q   <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      word_q  <= word_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================================
  // Decode
  cwd_pkg::cwd_dec_type dec;
  cwd_pkg::cwd_dec_type dec_q;

  cwd_field_dec u_dec (
    .word_in (word_q),
    .dec_out (dec)
  );

  // Outputs not gated by valid: zero in reset, then the erased-word decode,
  // watchdog and brown-out on, protection off, until the word is known.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec;
    end
  end

  assign cfg_valid_out             = valid_q;
  assign code_protect_on_out       = dec_q.prot_on;
  assign protect_lo_out            = dec_q.prot_lo;
  assign protect_hi_out            = dec_q.prot_hi;
  assign brownout_trip_voltage_out = dec_q.bor_tenths;
  assign brownout_reset_en_out     = dec_q.bor_en;
  assign powerup_timer_en_out      = dec_q.powerup_timer_en;
  assign watchdog_en_out           = dec_q.wdt_en;
  assign osc_mode_sel_out          = dec_q.osc_mode;
  assign ext_clock_allowed_out     = dec_q.ext_clk_ok;

  // ==========================================================================
  // APB slave: read only except the status lock bit, zero wait states
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        lock_q, lock_d;
  logic        setup;

  assign setup = psel_in & ~penable_in;

  always_comb begin
    rdata_d = rdata_q;
    err_d   = 1'b0;
    lock_d  = lock_q;
    if (setup) begin
      rdata_d = '0;
      err_d   = pwrite_in;
      case (paddr_in)
        cwd_pkg::OFS_WORD: begin
          rdata_d[13:0]                 = word_q;
          rdata_d[cwd_pkg::UNIMPL_BIT]  = 1'b1;
        end
        cwd_pkg::OFS_DECODE: begin
          rdata_d[1:0]   = dec_q.osc_mode;
          rdata_d[2]     = dec_q.wdt_en;
          rdata_d[3]     = dec_q.powerup_timer_en;
          rdata_d[4]     = dec_q.bor_en;
          rdata_d[5]     = dec_q.ext_clk_ok;
          rdata_d[6]     = dec_q.prot_on;
          rdata_d[13:8]  = dec_q.bor_tenths;
        end
        cwd_pkg::OFS_RANGE: begin
          rdata_d[11:0]  = dec_q.prot_lo;
          rdata_d[27:16] = dec_q.prot_hi;
        end
        cwd_pkg::OFS_STATUS: begin
          rdata_d[0] = valid_q;
          rdata_d[1] = lock_q;
          // Status is the one writable word; its lock bit is applied in the access phase
          if (pwrite_in) begin
            err_d = 1'b0;
          end
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
      // Writes to a locked map always error
      if (pwrite_in && lock_q) begin
        err_d = 1'b1;
      end
    end
    // Write takes effect only at the completing access edge
    if (psel_in && penable_in && pready_out && pwrite_in && !lock_q &&
        (paddr_in == cwd_pkg::OFS_STATUS) && pwdata_in[1]) begin
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
      lock_q  <= lock_d;
    end
  end

  // Zero wait states: every access completes one cycle after setup
  assign pready_out  = 1'b1;
  assign prdata_out  = rdata_q;
  assign pslverr_out = psel_in & penable_in & err_q;

  // ==========================================================================
  // Checks
  a_osc_hs_only: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ext_clock_allowed_out == (osc_mode_sel_out == 2'h2))
    else $error("external clock allowed outside high-speed mode");

  a_wdt_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |-> watchdog_en_out == word_q[2])
    else $error("watchdog enable mismatch");

  a_powerup_timer_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |-> powerup_timer_en_out == !word_q[3])
    else $error("power-up timer polarity wrong");

  a_bor_enable: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |-> brownout_reset_en_out == word_q[6])
    else $error("brown-out enable mismatch");

  a_bor_level: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |->
      brownout_trip_voltage_out == (word_q[11:10] == 2'h3 ? 6'h19 : word_q[11:10] == 2'h2 ? 6'h1B :
                                    word_q[11:10] == 2'h1 ? 6'h2A : 6'h2D))
    else $error("brown-out trip level wrong");

  a_cp_range: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |->
      (code_protect_on_out == (word_q[13:12] != 2'h3)) &&
      (!code_protect_on_out || (protect_hi_out == 12'hFFF &&
        protect_lo_out == (word_q[13:12] == 2'h2 ? 12'h800 : word_q[13:12] == 2'h1 ? 12'h400 : 12'h000))))
    else $error("code protection range wrong");

  a_osc_mode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |-> osc_mode_sel_out == word_q[1:0])
    else $error("oscillator mode mismatch");

  a_rc_code: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    valid_q ##1 valid_q |-> (osc_mode_sel_out == 2'h3) == (word_q[1:0] == 2'h3))
    else $error("resistor capacitor code wrong");

  // Keyed on the counter, not on reset release, so the release edge cannot start a false attempt
  sequence s_release;
    !valid_q && (cnt_q == 2'h2);
  endsequence
  a_latch_once: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_release |=> valid_q ##1 $stable(word_q))
    else $error("word not latched three cycles after reset");

endmodule // cwd_top
`default_nettype wire

/* dv/config_word_decoder_test.sv */
// Self-checking bench for the configuration word decoder.
// Assumes cwd_pkg and cwd_top are compiled first; the bench drives APB and the word pin.
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder_test;
  logic        clk_sys_in;
  logic        rstn_in;
  logic [13:0] cfg_word_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic        pready_out;
  logic [31:0] prdata_out;
  logic        pslverr_out;
  logic        cfg_valid_out;
  logic        code_protect_on_out;
  logic [11:0] protect_lo_out;
  logic [11:0] protect_hi_out;
  logic [5:0]  brownout_trip_voltage_out;
  logic        brownout_reset_en_out;
  logic        powerup_timer_en_out;
  logic        watchdog_en_out;
  logic [1:0]  osc_mode_sel_out;
  logic        ext_clock_allowed_out;
  logic [31:0] dec_seen;
  logic [31:0] rng_seen;
  logic [31:0] seed;
  int          n_errors = 0;
  int          num_checks = 0;

  cwd_top cwd_top_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cfg_word_in(cfg_word_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .cfg_valid_out(cfg_valid_out), .code_protect_on_out(code_protect_on_out),
    .protect_lo_out(protect_lo_out), .protect_hi_out(protect_hi_out),
    .brownout_trip_voltage_out(brownout_trip_voltage_out), .brownout_reset_en_out(brownout_reset_en_out),
    .powerup_timer_en_out(powerup_timer_en_out), .watchdog_en_out(watchdog_en_out),
    .osc_mode_sel_out(osc_mode_sel_out), .ext_clock_allowed_out(ext_clock_allowed_out));

  // Ports packed in the same layout as the decode register
  assign dec_seen = {18'h0, brownout_trip_voltage_out, 1'b0, code_protect_on_out, ext_clock_allowed_out,
                     brownout_reset_en_out, powerup_timer_en_out, watchdog_en_out, osc_mode_sel_out};
  assign rng_seen = {4'h0, protect_hi_out, 4'h0, protect_lo_out};

  // ==========================================================================
  // Expectations
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [5:0] trip(input logic [1:0] v);
    case (v)
      2'h3: return 6'h19;
      2'h2: return 6'h1B;
      2'h1: return 6'h2A;
      default: return 6'h2D;
    endcase
  endfunction

  function automatic logic [31:0] exp_dec(input logic [13:0] w);
    return {18'h0, trip(w[11:10]), 1'b0, w[13:12] != 2'h3, w[1:0] == 2'h2, w[6], ~w[3], w[2], w[1:0]};
  endfunction

  function automatic logic [31:0] exp_rng(input logic [13:0] w);
    case (w[13:12])
      2'h2: return 32'h0FFF0800;
      2'h1: return 32'h0FFF0400;
      2'h0: return 32'h0FFF0000;
      default: return 32'h0;
    endcase
  endfunction

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write: exp bit 0 is the expected error flag; read: masked data compared
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp,
                     input string what);
    int k;
    @(posedge clk_sys_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= 32'h2;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys_in);
      if (pready_out === 1'b1) break;
    end
    if (k == 16) begin
      n_errors++;
      tally_and_finish();
    end
    if (wr) chk(what, {31'h0, pslverr_out}, exp);
    else chk(what, prdata_out & msk, exp);
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // One reset per word, since the word is sampled only once after reset
  task automatic run_word(input logic [13:0] w);
    logic [31:0] m;
    int          k;
    m = (w[13:12] == 2'h3) ? 32'h0FFF0000 : 32'hFFFFFFFF;
    @(posedge clk_sys_in);
    rstn_in     <= 1'b0;
    cfg_word_in <= w;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("erased_decode", dec_seen, exp_dec(14'h3FFF));
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys_in);
      if (cfg_valid_out === 1'b1) break;
    end
    if (k == 8) begin
      n_errors++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk_sys_in);
    chk("decode", dec_seen, exp_dec(w));
    chk("range", rng_seen & m, exp_rng(w));
    // Pin changes after sampling must not reach the outputs
    cfg_word_in <= ~w;
    acc(1'b1, 12'h000, 32'h0, 32'h1, "word_write_err");
    acc(1'b0, 12'h000, 32'hFFFFFFFF, {18'h0, w | 14'h0080}, "word_read");
    acc(1'b0, 12'h004, 32'hFFFFFFFF, exp_dec(w), "decode_read");
    acc(1'b0, 12'h008, m, exp_rng(w), "range_read");
    acc(1'b1, 12'h020, 32'h0, 32'h1, "unmapped_write_err");
    acc(1'b0, 12'h00C, 32'hFFFFFFFF, 32'h1, "status_unlocked");
    acc(1'b1, 12'h00C, 32'h0, 32'h0, "lock_write_ok");
    acc(1'b0, 12'h00C, 32'hFFFFFFFF, 32'h3, "status_locked");
    acc(1'b1, 12'h00C, 32'h0, 32'h1, "locked_write_err");
    chk("decode_held", dec_seen, exp_dec(w));
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    logic [1:0] c;
    rstn_in     = 1'b0;
    cfg_word_in = 14'h3FFF;
    psel_in     = 1'b0;
    penable_in  = 1'b0;
    pwrite_in   = 1'b0;
    paddr_in    = 12'h000;
    pwdata_in   = 32'h0;
    seed        = 32'h6B36B0E4;
    repeat (4) @(posedge clk_sys_in);
    // Every code of every field, protection pairs kept equal
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      run_word({c, c, c, c[0], c[1], c, c[1], c[0], c});
    end
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      run_word({seed[1:0], seed[3:2], seed[1:0], seed[4], seed[5], seed[1:0], seed[6], seed[7], seed[9:8]});
    end
    tally_and_finish();
  end
endmodule // config_word_decoder_test
`default_nettype wire
